/* rtl/aos_regs.svh */
// constants for the adc operation sequencer
`ifndef AOS_REGS_SVH
`define AOS_REGS_SVH
// synchroniser reset levels: strobe, data, clock, frame sync, select
`define AOS_SYNC_IDLE    5'h1b
`define AOS_FRAME_BITS   5'h10
`define AOS_CMD_BITS     5'h04
`define AOS_CMD_CFG      4'ha
`define AOS_CMD_READ     4'he
`define AOS_CFG_MODE     6:5
`define AOS_CFG_STROBE   7
`define AOS_CFG_THR      1:0
`define AOS_FIFO_DEPTH   8
`define AOS_CLK_NS       10
`define AOS_OSC_KHZ      6500
`define AOS_CONV_CLKS    18
`define AOS_CONV_EXT_NS  15
`define AOS_CONV_CYC     ((`AOS_CONV_CLKS * 1000000 + \
   `AOS_OSC_KHZ * `AOS_CONV_EXT_NS + `AOS_OSC_KHZ * `AOS_CLK_NS - 1) / \
   (`AOS_OSC_KHZ * `AOS_CLK_NS))
`endif

/* rtl/aos_pkg.sv */
// types of the adc operation sequencer
package aos_pkg;
   typedef enum logic [2:0] {
      AOS_IDLE = 3'h1,
      AOS_CONV = 3'h2,
      AOS_DONE = 3'h4
   } aos_state_e;
   typedef enum logic [1:0] {
      AOS_ONESHOT = 2'h0,
      AOS_REPEAT  = 2'h1,
      AOS_SWEEP   = 2'h2,
      AOS_RSWEEP  = 2'h3
   } aos_mode_e;
   typedef logic [13:0] aos_data_t;
endpackage

/* rtl/aos_link_if.sv */
// frame engine to sequencer signals
interface aos_link_if;
   logic        cs_fall;
   logic        cs_n_s;
   logic        fs_rise;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        sdi_s;
   logic [15:0] load_word;
   logic        frame_start;
   logic        cmd_valid;
   logic [3:0]  cmd;
   logic        frame_done;
   logic [15:0] word;
   logic        frame_act;
   logic        sdo_bit;
   modport engine (input cs_fall, cs_n_s, fs_rise, sclk_rise, sclk_fall,
                   sdi_s, load_word,
                   output frame_start, cmd_valid, cmd, frame_done, word,
                   frame_act, sdo_bit);
   modport seq (output cs_fall, cs_n_s, fs_rise, sclk_rise, sclk_fall,
                sdi_s, load_word,
                input frame_start, cmd_valid, cmd, frame_done, word,
                frame_act, sdo_bit);
endinterface

/* rtl/aos_frame.sv */
// serial frame engine: 16-bit shift in and out
`include "aos_regs.svh"
module aos_frame
   import aos_pkg::*;
(
   input wire logic   clock,
   input wire logic   reset,
   aos_link_if.engine lk
);
   logic        act_ff;
   logic [4:0]  cnt_ff;
   logic [15:0] sin_ff;
   logic [15:0] sout_ff;
   logic        last_bit;

   // frame opens on select fall, or frame sync rise while selected
   assign lk.frame_start = !act_ff && (lk.cs_fall ||
                           (lk.fs_rise && !lk.cs_n_s));
   assign last_bit = cnt_ff == (`AOS_FRAME_BITS - 5'h01);
   assign lk.frame_done = act_ff && lk.sclk_fall && last_bit;
   assign lk.cmd_valid = act_ff && lk.sclk_fall &&
                         cnt_ff == (`AOS_CMD_BITS - 5'h01);
   assign lk.cmd = {sin_ff[2:0], lk.sdi_s};
   assign lk.word = {sin_ff[14:0], lk.sdi_s};
   assign lk.frame_act = act_ff;
   assign lk.sdo_bit = sout_ff[15];

   always_ff @(posedge clock) begin
      if (reset) begin
         act_ff <= 1'b0;
      end else if (lk.frame_start) begin
         act_ff <= 1'b1;
      end else if (lk.frame_done || (lk.cs_n_s && !lk.fs_rise &&
                   lk.sclk_rise && cnt_ff == 5'h00)) begin
         act_ff <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset || lk.frame_start) begin
         cnt_ff <= 5'h00;
         sin_ff <= 16'h0000;
      end else if (act_ff && lk.sclk_fall) begin
         cnt_ff <= cnt_ff + 5'h01;
         sin_ff <= {sin_ff[14:0], lk.sdi_s};
      end
   end

   // host samples on falling edges, so bit 15 is valid before the first
   always_ff @(posedge clock) begin
      if (reset) begin
         sout_ff <= 16'h0000;
      end else if (lk.frame_start) begin
         sout_ff <= lk.load_word;
      end else if (act_ff && lk.sclk_rise && cnt_ff != 5'h00) begin
         sout_ff <= {sout_ff[14:0], 1'b0};
      end
   end
endmodule

/* rtl/aos_sequencer.sv */
// operation-cycle sequencer of a serially controlled multichannel adc
`include "aos_regs.svh"
module aos_sequencer
   import aos_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        cs_n,
   input  wire logic        frame_sync,
   input  wire logic        sclk,
   input  wire logic        serial_in,
   input  wire logic        conv_start_strobe_n,
   input  wire logic [13:0] adc_data,
   output logic             serial_out,
   output logic             serial_out_oe,
   output logic             eoc,
   output logic             int_n,
   output logic [2:0]       sample_chan
);
   localparam int NSYNC = 5;
   localparam logic [8:0] CONV_CYC = 9'(`AOS_CONV_CYC);
   // idle pin levels, so no false edge follows reset
   localparam logic [NSYNC-1:0] SYNC_IDLE = `AOS_SYNC_IDLE;

   aos_link_if lk ();

   logic [NSYNC-1:0] raw;
   logic [NSYNC-1:0] s1_ff;
   logic [NSYNC-1:0] s2_ff;
   logic [NSYNC-1:0] s3_ff;

   assign raw = {conv_start_strobe_n, serial_in, sclk, frame_sync, cs_n};

   genvar g;
   generate
      for (g = 0; g < NSYNC; g++) begin : g_sync
         always_ff @(posedge clock) begin
            if (reset) begin
               s1_ff[g] <= SYNC_IDLE[g];
               s2_ff[g] <= SYNC_IDLE[g];
               s3_ff[g] <= SYNC_IDLE[g];
            end else begin
               s1_ff[g] <= raw[g];
               s2_ff[g] <= s1_ff[g];
               s3_ff[g] <= s2_ff[g];
            end
         end
      end
   endgenerate

   logic strobe_rise;
   assign lk.cs_n_s    = s2_ff[0];
   assign lk.cs_fall   = s3_ff[0] && !s2_ff[0];
   assign lk.fs_rise   = !s3_ff[1] && s2_ff[1];
   assign lk.sclk_rise = !s3_ff[2] && s2_ff[2];
   assign lk.sclk_fall = s3_ff[2] && !s2_ff[2];
   assign lk.sdi_s     = s2_ff[3];
   assign strobe_rise  = !s3_ff[4] && s2_ff[4];

   aos_frame u_frame (
      .clock (clock),
      .reset (reset),
      .lk    (lk)
   );

   function automatic logic [3:0] thr_of(input logic [1:0] code);
      thr_of = 4'h8 - {1'b0, code, 1'b0};
   endfunction

   aos_state_e state_ff;
   aos_mode_e  mode_ff;
   logic       strobe_trig_ff;
   logic [1:0] thr_ff;
   aos_data_t  fifo_ff [`AOS_FIFO_DEPTH];
   logic [3:0] wr_ff;
   logic [3:0] rd_ff;
   aos_data_t  result_ff;
   logic       pending_ff;
   logic       spec_ff;
   logic       sess_ff;
   logic       kill_ff;
   logic       armed_ff;
   logic       run_ff;
   logic [8:0] cnt_ff;
   logic [2:0] chan_ff;
   logic       int_n_ff;

   logic       fifo_used;
   logic       is_cfg;
   logic       is_sel;
   logic       go;
   logic       restart;
   logic       conv_end;
   logic       run_full;

   assign fifo_used = mode_ff != AOS_ONESHOT;
   assign is_cfg = lk.frame_done && lk.word[15:12] == `AOS_CMD_CFG && !sess_ff;
   assign is_sel = lk.frame_done && !lk.word[15] && !sess_ff && !spec_ff;
   assign conv_end = state_ff == AOS_CONV && cnt_ff == 9'h000;
   assign run_full = wr_ff + 4'h1 == thr_of(thr_ff);

   // which event starts a conversion, and whether it opens a fresh run
   always_comb begin
      go = 1'b0;
      restart = 1'b0;
      if (state_ff != AOS_CONV) begin
         if (strobe_trig_ff && strobe_rise) begin
            unique case (mode_ff)
               AOS_ONESHOT: go = 1'b1;
               AOS_REPEAT, AOS_RSWEEP: begin
                  go = armed_ff;
                  restart = armed_ff && (pending_ff || !run_ff);
               end
               AOS_SWEEP: begin
                  go = armed_ff && !pending_ff;
                  restart = go && !run_ff;
               end
            endcase
         end else if (!strobe_trig_ff && is_sel) begin
            unique case (mode_ff)
               AOS_ONESHOT: go = 1'b1;
               AOS_REPEAT, AOS_RSWEEP: begin
                  go = 1'b1;
                  restart = pending_ff || !run_ff;
               end
               AOS_SWEEP: begin
                  go = !pending_ff;
                  restart = go && !run_ff;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_ff <= AOS_IDLE;
         cnt_ff <= 9'h000;
      end else if (go) begin
         state_ff <= AOS_CONV;
         cnt_ff <= CONV_CYC - 9'h001;
      end else if (conv_end) begin
         state_ff <= fifo_used && !run_full ? AOS_IDLE : AOS_DONE;
      end else if (state_ff == AOS_CONV) begin
         cnt_ff <= cnt_ff - 9'h001;
      end else if (is_cfg || lk.frame_start) begin
         state_ff <= AOS_IDLE;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         mode_ff <= AOS_ONESHOT;
         strobe_trig_ff <= 1'b0;
         thr_ff <= 2'h0;
      end else if (is_cfg) begin
         mode_ff <= aos_mode_e'(lk.word[`AOS_CFG_MODE]);
         strobe_trig_ff <= lk.word[`AOS_CFG_STROBE];
         thr_ff <= lk.word[`AOS_CFG_THR];
      end
   end

   // results pending after a finished operation
   always_ff @(posedge clock) begin
      if (reset) begin
         pending_ff <= 1'b0;
         run_ff <= 1'b0;
      end else if (conv_end) begin
         pending_ff <= !fifo_used || run_full;
         run_ff <= fifo_used && !run_full;
      end else if (is_cfg) begin
         pending_ff <= 1'b0;
         run_ff <= 1'b0;
      end else if (go) begin
         pending_ff <= 1'b0;
         run_ff <= fifo_used;
      end else if (lk.cmd_valid && spec_ff && lk.cmd == `AOS_CMD_READ) begin
         pending_ff <= 1'b0;
      end else if (lk.frame_start && !fifo_used) begin
         pending_ff <= 1'b0;
      end
   end

   // arming: selects arm strobe runs; sweep needs a fresh arm period
   always_ff @(posedge clock) begin
      if (reset || is_cfg) begin
         armed_ff <= 1'b0;
      end else if (strobe_trig_ff && is_sel) begin
         armed_ff <= 1'b1;
      end else if (lk.cmd_valid && spec_ff && lk.cmd == `AOS_CMD_READ &&
                   mode_ff != AOS_RSWEEP) begin
         armed_ff <= mode_ff == AOS_ONESHOT;
      end else if (conv_end && run_full && mode_ff == AOS_SWEEP) begin
         armed_ff <= 1'b0;
      end
   end

   // speculative first-entry output and the fifo read session
   always_ff @(posedge clock) begin
      if (reset || is_cfg) begin
         spec_ff <= 1'b0;
         sess_ff <= 1'b0;
         kill_ff <= 1'b0;
         rd_ff <= 4'h0;
      end else if (lk.frame_start) begin
         spec_ff <= fifo_used && pending_ff && !sess_ff;
         kill_ff <= 1'b0;
         // entry rd_ff is loaded on this edge; point at the next one
         if (sess_ff) begin
            rd_ff <= rd_ff + 4'h1;
         end
      end else if (lk.cmd_valid && spec_ff) begin
         spec_ff <= 1'b0;
         if (lk.cmd == `AOS_CMD_READ) begin
            sess_ff <= 1'b1;
            rd_ff <= 4'h1;
         end else begin
            kill_ff <= 1'b1;
         end
      end else if (lk.frame_done && sess_ff && rd_ff >= wr_ff) begin
         sess_ff <= 1'b0;
         rd_ff <= 4'h0;
      end else if (!lk.frame_act && sess_ff && rd_ff >= wr_ff) begin
         sess_ff <= 1'b0;
         rd_ff <= 4'h0;
      end
   end

   // write side; reads and config writes never touch the converter
   always_ff @(posedge clock) begin
      if (reset || is_cfg) begin
         wr_ff <= 4'h0;
      end else if (go && restart) begin
         wr_ff <= 4'h0;
      end else if (conv_end && fifo_used) begin
         fifo_ff[wr_ff[2:0]] <= adc_data;
         wr_ff <= wr_ff + 4'h1;
      end else if (sess_ff && !lk.frame_act && rd_ff >= wr_ff) begin
         wr_ff <= 4'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         result_ff <= 14'h0000;
      end else if (conv_end && !fifo_used) begin
         result_ff <= adc_data;
      end
   end

   // channel: repeat keeps the selected one, sweeps step through
   always_ff @(posedge clock) begin
      if (reset) begin
         chan_ff <= 3'h0;
      end else if (is_sel && !run_ff && state_ff != AOS_CONV &&
                   (mode_ff == AOS_ONESHOT || mode_ff == AOS_REPEAT)) begin
         chan_ff <= lk.word[14:12];
      end else if (go && restart && mode_ff[1]) begin
         chan_ff <= 3'h0;
      end else if (conv_end && mode_ff[1]) begin
         chan_ff <= chan_ff + 3'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset || is_cfg || go) begin
         int_n_ff <= 1'b1;
      end else if (conv_end && (!fifo_used || run_full)) begin
         int_n_ff <= 1'b0;
      end else if (lk.frame_start) begin
         int_n_ff <= 1'b1;
      end
   end

   assign lk.load_word = (fifo_used && pending_ff) || sess_ff ?
                         {2'h0, fifo_ff[rd_ff[2:0]]} :
                         {2'h0, result_ff};
   assign serial_out    = lk.sdo_bit;
   assign serial_out_oe = lk.frame_act && !kill_ff &&
                          (!fifo_used || spec_ff || sess_ff);
   assign eoc           = state_ff != AOS_CONV;
   assign int_n         = int_n_ff;
   assign sample_chan   = chan_ff;
endmodule

/* dv/aos_checker.sv */
// concurrent checks on the sequencer pins
module aos_checker
   import aos_pkg::*;
(
   input wire logic        clock,
   input wire logic        reset,
   input wire logic        cs_n,
   input wire logic        frame_sync,
   input wire logic        sclk,
   input wire logic        serial_in,
   input wire logic        conv_start_strobe_n,
   input wire logic [13:0] adc_data,
   input wire logic        serial_out,
   input wire logic        serial_out_oe,
   input wire logic        eoc,
   input wire logic        int_n,
   input wire logic [2:0]  sample_chan
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   logic [8:0] low_cnt_ff;
   // conversion length is too long for a repetition, so count it
   always_ff @(posedge clock) begin
      if (reset || eoc)
         low_cnt_ff <= 9'h0;
      else
         low_cnt_ff <= low_cnt_ff + 9'h1;
   end
   a_eoc_width: assert property ($rose(eoc) |-> low_cnt_ff == 9'h117)
      else $error("conversion period has the wrong length");
   a_int_at_end: assert property ($fell(int_n) |->
      eoc && (!$past(eoc) || !$past(eoc, 2)))
      else $error("interrupt raised away from a conversion end");
   a_int_quiet: assert property (!eoc && !$past(eoc) |-> int_n)
      else $error("interrupt low during a conversion");
   a_int_cause: assert property ($rose(int_n) |-> !eoc || !$past(cs_n))
      else $error("interrupt cleared without frame or conversion");
   a_oe_idle: assert property (cs_n [*6] |-> !serial_out_oe)
      else $error("output driven with no frame");
   a_oe_start: assert property ($rose(serial_out_oe) |-> !cs_n)
      else $error("output enabled outside a selected frame");
   a_chan_hold: assert property (
      !eoc && $past(!eoc) |-> $stable(sample_chan))
      else $error("channel changed during a conversion");
   a_reset_state: assert property ($fell(reset) |-> eoc && int_n &&
      !serial_out_oe && sample_chan == 3'h0)
      else $error("outputs not at reset state");
   c_conv: cover property ($fell(eoc));
   c_int: cover property ($fell(int_n));
   c_out: cover property ($rose(serial_out_oe));
endmodule

/* dv/aos_host.sv */
// host serial port model: select, clock and data lines
module aos_host (
   input  wire logic clock,
   input  wire logic serial_out,
   input  wire logic serial_out_oe,
   output logic      cs_n,
   output logic      frame_sync,
   output logic      sclk,
   output logic      serial_in
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      cs_n = 1'b1;
      frame_sync = 1'b1;
      sclk = 1'b0;
      serial_in = 1'b0;
   end
   task automatic half;
      repeat (8) @(posedge clock);
      #1;
   endtask
   // whole 16-bit words only; clock stands low between frames
   task automatic xfer(input logic [15:0] w, output logic [15:0] r,
                       output logic oe_first, output logic oe_last);
      repeat (4) @(posedge clock);
      #1;
      cs_n = 1'b0;
      half();
      for (int i = 15; i >= 0; i--) begin
         sclk = 1'b1;
         serial_in = w[i];
         repeat (8) @(posedge clock);
         #1;
         // a released line must not read as the driven bit
         r[i] = serial_out_oe ? serial_out : !serial_out;
         if (i == 15)
            oe_first = serial_out_oe;
         if (i == 0)
            oe_last = serial_out_oe;
         sclk = 1'b0;
         half();
      end
      cs_n = 1'b1;
      // undriven data line must not look like the last bit
      serial_in = ~w[0];
   endtask
endmodule

/* dv/tb_top.sv */
// self-checking bench of the operation sequencer
module tb_top;
   import aos_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [15:0] w;
      logic        conv;
      logic [2:0]  chan;
   } aos_row_s;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic        conv_start_strobe_n = 1'b1;
   logic [13:0] adc_data = 14'h1a5c;
   logic        cs_n;
   logic        frame_sync;
   logic        sclk;
   logic        serial_in;
   logic        serial_out;
   logic        serial_out_oe;
   logic        eoc;
   logic        int_n;
   logic [2:0]  sample_chan;
   logic [15:0] rx;
   logic        of_s;
   logic        ol_s;
   int          fail_count = 0;
   int          checked = 0;
   aos_row_s    rows [4] = '{'{16'h3000, 1'b1, 3'h3},
      '{16'h5000, 1'b1, 3'h5}, '{16'ha000, 1'b0, 3'h0},
      '{16'h1000, 1'b1, 3'h1}};
   always #5 clock = ~clock;
   aos_sequencer i_dut (.clock(clock), .reset(reset), .cs_n(cs_n),
      .frame_sync(frame_sync), .sclk(sclk), .serial_in(serial_in),
      .conv_start_strobe_n(conv_start_strobe_n), .adc_data(adc_data),
      .serial_out(serial_out), .serial_out_oe(serial_out_oe),
      .eoc(eoc), .int_n(int_n), .sample_chan(sample_chan));
   aos_host i_host (.clock(clock), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe), .cs_n(cs_n),
      .frame_sync(frame_sync), .sclk(sclk), .serial_in(serial_in));
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checked %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wait_eoc;
      int n = 0;
      while (eoc !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      if (eoc !== 1'b1) begin
         fail_count++;
         print_verdict();
      end
      tick(2);
   endtask
   task automatic strobe;
      conv_start_strobe_n = 1'b0;
      tick(4);
      conv_start_strobe_n = 1'b1;
      tick(6);
   endtask
   task automatic op(input logic [15:0] w, input logic conv,
                     input logic [2:0] chan);
      i_host.xfer(w, rx, of_s, ol_s);
      tick(1);
      check(16'(eoc), 16'(!conv));
      check(16'(int_n), 16'h1);
      if (conv) begin
         check(16'(sample_chan), 16'(chan));
         wait_eoc();
      end
   endtask
   initial begin
      tick(4);
      reset = 1'b0;
      tick(4);
      check(16'({eoc, int_n, serial_out_oe, sample_chan}), 16'h30);
      $display("test reset done");
      foreach (rows[k]) begin
         op(rows[k].w, rows[k].conv, rows[k].chan);
         check(16'(of_s), 16'h1);
         if (k > 0)
            check(rx, {2'h0, adc_data});
         if (rows[k].conv)
            check(16'(int_n), 16'h0);
      end
      $display("test one-shot table done");
      op(16'ha080, 1'b0, 3'h0);
      for (int n = 0; n < 2; n++) begin
         // second strobe comes with the result still unread
         strobe();
         check(16'(eoc), 16'h0);
         wait_eoc();
      end
      // keep the result: read it out before the next strobe
      op(16'h0000, 1'b0, 3'h0);
      check(rx, {2'h0, adc_data});
      strobe();
      check(16'(eoc), 16'h0);
      wait_eoc();
      $display("test one-shot strobe done");
      op(16'ha0a3, 1'b0, 3'h0);
      op(16'h2000, 1'b0, 3'h0);
      for (int n = 0; n < 4; n++) begin
         strobe();
         check(16'({eoc, sample_chan}), 16'h2);
         wait_eoc();
         if (n[0])
            check(16'(int_n), 16'h0);
      end
      i_host.xfer(16'h2000, rx, of_s, ol_s);
      check(16'({of_s, ol_s}), 16'h2);
      $display("test repeat strobe done");
      op(16'ha043, 1'b0, 3'h0);
      op(16'h0000, 1'b1, 3'h0);
      op(16'h0000, 1'b1, 3'h1);
      check(16'(int_n), 16'h0);
      op(16'he000, 1'b0, 3'h0);
      check(16'({of_s, ol_s}), 16'h3);
      check(rx, {2'h0, adc_data});
      op(16'he000, 1'b0, 3'h0);
      check(16'({of_s, ol_s}), 16'h3);
      check(rx, {2'h0, adc_data});
      op(16'h0000, 1'b1, 3'h0);
      op(16'h0000, 1'b1, 3'h1);
      op(16'h0000, 1'b0, 3'h0);
      $display("test sweep done");
      op(16'ha023, 1'b0, 3'h0);
      op(16'h3000, 1'b1, 3'h3);
      op(16'h0000, 1'b1, 3'h3);
      check(16'(int_n), 16'h0);
      // select over unread results opens a fresh run on the new channel
      op(16'h5000, 1'b1, 3'h5);
      $display("test repeat select done");
      op(16'ha0e3, 1'b0, 3'h0);
      op(16'h0000, 1'b0, 3'h0);
      for (int n = 0; n < 3; n++) begin
         strobe();
         check(16'({eoc, sample_chan}), 16'(n % 2));
         wait_eoc();
         if (n == 1)
            check(16'(int_n), 16'h0);
      end
      $display("test repeat sweep strobe done");
      op(16'ha000, 1'b0, 3'h0);
      i_host.xfer(16'h1000, rx, of_s, ol_s);
      tick(2);
      // reset lands in mid-conversion
      reset = 1'b1;
      tick(4);
      reset = 1'b0;
      tick(1);
      check(16'({eoc, int_n, serial_out_oe, sample_chan}), 16'h30);
      $display("test mid-run reset done");
      print_verdict();
   end
endmodule
bind aos_sequencer aos_checker i_chk (.clock(clock), .reset(reset),
   .cs_n(cs_n), .frame_sync(frame_sync), .sclk(sclk),
   .serial_in(serial_in), .conv_start_strobe_n(conv_start_strobe_n),
   .adc_data(adc_data), .serial_out(serial_out),
   .serial_out_oe(serial_out_oe), .eoc(eoc), .int_n(int_n),
   .sample_chan(sample_chan));
